// *** rtl/dsv_objects.sv ***
// Purpose: Status word encoding and velocity-mode objects with ramp generator
// Assumes: Requests are one-cycle strobes synchronous to ref_clk
// Notes:   Answers come one cycle after the request, from flip-flops
`timescale 1ns/1ps

// Notes on behaviour
// - The status word is a read-only 16-bit object the master may read.
// - Status bits 0 to 3, 5 and 6 always follow the present drive state; bit 4 is voltage present.
// - Bits 6,5,3,2,1,0 take the fixed pattern defined for each state.
// - Bit 7 flags a warning while the drive keeps running.
// - Bits 10, 12, 13 carry target, homing and following meanings by mode.
// - Target velocity is a signed RPM command, reset zero, used in velocity mode.
// - Velocity demand is the read-only signed RPM value computed here.
// - Actual velocity is a read-only signed RPM value from measurement.
// - Ramp-up time in ms sets acceleration from zero to target, default 10000.
// - Slow-down time in ms sets deceleration to zero, default 10000.
// - Quick-stop time in ms sets quick-stop deceleration, default 1000.
// - Quick-stop time range depends on the time-unit setting.
module dsv_objects (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// Object access
	input  wire dsv_pkg::dsv_req_s    req,
	output logic                      ack,
	output logic                      err,
	output logic [31:0]               rdata,
	// Drive condition
	input  wire dsv_pkg::dsv_drive_s  drive,
	input  wire logic                 drive_time_unit_param,
	input  wire logic signed [15:0]   speed_measured,
	// Outputs to the motor control core
	output logic [15:0]               drive_state_word,
	output logic signed [15:0]        velocity_command
);
	import dsv_pkg::*;

	logic [15:0]        status_next;
	logic [15:0]        status_reg;
	logic signed [15:0] target_velocity_reg;
	logic signed [15:0] velocity_demand_reg;
	logic signed [15:0] velocity_actual_reg;
	logic [31:0]        ramp_up_time_reg;
	logic [31:0]        slow_down_time_reg;
	logic [31:0]        quick_stop_time_reg;
	logic [17:0]        tick_cnt_reg;
	logic               tick;
	logic [31:0]        ms_cnt_reg;
	logic               vel_mode;
	logic               stopping;
	logic signed [15:0] ramp_goal;
	logic [31:0]        ramp_time;
	logic               qs_ok;

	function automatic logic known_index(input logic [15:0] idx);
		return idx == IDX_STATUS || idx == IDX_TARGET_VEL ||
			idx == IDX_VEL_DEMAND || idx == IDX_VEL_ACTUAL ||
			idx == IDX_RAMP_UP || idx == IDX_SLOW_DOWN ||
			idx == IDX_QUICK_STOP;
	endfunction

	function automatic logic writable_index(input logic [15:0] idx);
		return idx == IDX_TARGET_VEL || idx == IDX_RAMP_UP ||
			idx == IDX_SLOW_DOWN || idx == IDX_QUICK_STOP;
	endfunction

	assign vel_mode = drive.mode == DSV_MODE_VL;
	assign stopping = drive.state == DSV_QSTOP;
	// Range window moves with the time unit
	assign qs_ok = drive_time_unit_param ?
		(req.wdata >= QS_MIN_UNIT1 && req.wdata <= QS_MAX_UNIT1) :
		(req.wdata >= QS_MIN_UNIT0 && req.wdata <= QS_MAX_UNIT0);

	// Status word encoding
	always_comb begin
		status_next = 16'h0000;
		case (drive.state)
			DSV_NOT_READY:  status_next[6:0] = 7'h00;
			DSV_SW_DIS:     status_next[6:0] = 7'h40;
			DSV_READY:      status_next[6:0] = 7'h21;
			DSV_SWITCHED:   status_next[6:0] = 7'h23;
			DSV_OP_EN:      status_next[6:0] = 7'h27;
			DSV_QSTOP:      status_next[6:0] = 7'h07;
			DSV_FAULT_REAC: status_next[6:0] = 7'h0f;
			DSV_FAULT:      status_next[6:0] = 7'h08;
			default:        status_next[6:0] = 7'h00;
		endcase
		status_next[SW_VOLTAGE] = drive.voltage_present;
		status_next[SW_WARNING] = drive.warning;
		status_next[SW_REMOTE]  = drive.remote;
		case (drive.mode)
			DSV_MODE_PP, DSV_MODE_IP: begin
				status_next[SW_TARGET] = drive.target_reached;
				status_next[SW_FOLLOW] = drive.following_error;
			end
			DSV_MODE_HM: begin
				status_next[SW_TARGET] = drive.target_reached;
				status_next[SW_HOMED]  = drive.homing_attained;
				status_next[SW_FOLLOW] = drive.homing_error;
			end
			DSV_MODE_PT:
				status_next[SW_TARGET] = drive.target_reached;
			DSV_MODE_CSP:
				status_next[SW_FOLLOW] = drive.following_error;
			default: ;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_reg       <= 16'h0000;
			drive_state_word <= 16'h0000;
		end else begin
			status_reg       <= status_next;
			drive_state_word <= status_next;
		end
	end

	// Writable objects; out-of-range quick-stop values are refused
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			target_velocity_reg <= RST_TARGET_VEL;
			ramp_up_time_reg    <= RST_RAMP_UP;
			slow_down_time_reg  <= RST_SLOW_DOWN;
			quick_stop_time_reg <= RST_QUICK_STOP;
		end else if (req.wr) begin
			case (req.index)
				IDX_TARGET_VEL: target_velocity_reg <= req.wdata[15:0];
				IDX_RAMP_UP:    ramp_up_time_reg    <= req.wdata;
				IDX_SLOW_DOWN:  slow_down_time_reg  <= req.wdata;
				IDX_QUICK_STOP: if (qs_ok)
					quick_stop_time_reg <= req.wdata;
				default: ;
			endcase
		end
	end

	// Access answer one cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack   <= 1'b0;
			err   <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			ack <= req.rd | req.wr;
			err <= (req.rd && !known_index(req.index)) ||
				(req.wr && (!writable_index(req.index) ||
				(req.index == IDX_QUICK_STOP && !qs_ok)));
			if (req.rd) begin
				case (req.index)
					IDX_STATUS:     rdata <= {16'h0000, status_reg};
					IDX_TARGET_VEL: rdata <= {{16{target_velocity_reg[15]}},
						target_velocity_reg};
					IDX_VEL_DEMAND: rdata <= {{16{velocity_demand_reg[15]}},
						velocity_demand_reg};
					IDX_VEL_ACTUAL: rdata <= {{16{velocity_actual_reg[15]}},
						velocity_actual_reg};
					IDX_RAMP_UP:    rdata <= ramp_up_time_reg;
					IDX_SLOW_DOWN:  rdata <= slow_down_time_reg;
					IDX_QUICK_STOP: rdata <= quick_stop_time_reg;
					default:        rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Millisecond tick from the 200 MHz clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			tick_cnt_reg <= 18'h00000;
		else if (tick)
			tick_cnt_reg <= 18'h00000;
		else
			tick_cnt_reg <= tick_cnt_reg + 18'h00001;
	end
	assign tick = tick_cnt_reg == TICK_LAST;

	// Ramp goal and duration: quick stop and leaving velocity mode ramp to zero
	always_comb begin
		ramp_goal = (vel_mode && drive.state == DSV_OP_EN) ?
			target_velocity_reg : 16'sh0000;
		if (stopping)
			ramp_time = quick_stop_time_reg;
		else if (ramp_goal == 16'sh0000 ||
			(velocity_demand_reg > 0 && ramp_goal < velocity_demand_reg) ||
			(velocity_demand_reg < 0 && ramp_goal > velocity_demand_reg))
			ramp_time = slow_down_time_reg;
		else
			ramp_time = ramp_up_time_reg;
	end

	// Demand steps one RPM every ramp_time/|target| ms, approximated by
	// counting ms and stepping when count*|target| covers the ramp time.
	// Trade-off: whole-RPM steps, no fractional accumulator.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ms_cnt_reg          <= 32'h0000_0000;
			velocity_demand_reg <= 16'sh0000;
		end else if (velocity_demand_reg == ramp_goal) begin
			ms_cnt_reg <= 32'h0000_0000;
		end else if (tick) begin
			if (32'(ms_cnt_reg + 32'h1) * 32'(target_velocity_reg < 0 ?
				-target_velocity_reg : target_velocity_reg) >= ramp_time ||
				target_velocity_reg == 16'sh0000 || ramp_time == 32'h0) begin
				ms_cnt_reg <= 32'h0000_0000;
				velocity_demand_reg <= (ramp_goal > velocity_demand_reg) ?
					16'(velocity_demand_reg + 16'sh0001) :
					16'(velocity_demand_reg - 16'sh0001);
			end else
				ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			velocity_actual_reg <= 16'sh0000;
			velocity_command    <= 16'sh0000;
		end else begin
			velocity_actual_reg <= speed_measured;
			velocity_command    <= velocity_demand_reg;
		end
	end

	state_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		drive.state == DSV_OP_EN |=> status_reg[6:0] ==? 7'b01?0111)
		else $error("status bits wrong in operation enabled");
	fault_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		drive.state == DSV_FAULT |=> status_reg[3:0] == 4'h8 && !status_reg[6])
		else $error("status bits wrong in fault");
	warn_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> status_reg[SW_WARNING] == $past(drive.warning))
		else $error("warning bit does not follow");
	reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		status_reg[8] == 1'b0 && status_reg[11] == 1'b0 &&
		status_reg[15:14] == 2'b00)
		else $error("reserved status bit set");
	vl_mode_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		vel_mode |=> status_reg[SW_TARGET] == 1'b0 && status_reg[13:12] == 2'b00)
		else $error("mode bit set in velocity mode");
	status_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.rd && req.index == IDX_STATUS |=> ack && !err &&
		rdata[31:16] == 16'h0000)
		else $error("status read answer wrong");
	qs_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.wr && req.index == IDX_QUICK_STOP && !qs_ok
		|=> $stable(quick_stop_time_reg) && err)
		else $error("out-of-range quick stop accepted");
	actual_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> velocity_actual_reg == $past(speed_measured))
		else $error("actual velocity not sampled");
	demand_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!tick |=> $stable(velocity_demand_reg))
		else $error("demand moved between ticks");
	ramp_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.wr && req.index == IDX_RAMP_UP |=> ramp_up_time_reg == $past(req.wdata))
		else $error("ramp-up time not stored");
	slow_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.wr && req.index == IDX_SLOW_DOWN |=>
		slow_down_time_reg == $past(req.wdata))
		else $error("slow-down time not stored");
	qs_time_a: assert property (@(posedge ref_clk) disable iff (rst)
		stopping |-> ramp_time == quick_stop_time_reg)
		else $error("quick stop not using its time");
	tv_store_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.wr && req.index == IDX_TARGET_VEL |=>
		target_velocity_reg == $past(req.wdata[15:0]))
		else $error("target velocity not stored");
	qstop_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		drive.state == DSV_QSTOP |=> drive_state_word[6:5] == 2'b00 &&
		drive_state_word[3:0] == 4'h7)
		else $error("status bits wrong in quick stop");
	ready_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		drive.state == DSV_READY |=> drive_state_word[6:5] == 2'b01 &&
		drive_state_word[3:0] == 4'h1)
		else $error("status bits wrong in ready");
	ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.rd || req.wr |=> ack)
		else $error("request not acknowledged");
	ack_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!req.rd && !req.wr |=> !ack && !err)
		else $error("answer without a request");
	ro_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.wr && (req.index == IDX_STATUS || req.index == IDX_VEL_DEMAND ||
		req.index == IDX_VEL_ACTUAL) |=> err)
		else $error("write to read-only object accepted");
	goal_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(vel_mode && drive.state == DSV_OP_EN) |-> ramp_goal == 16'sh0000)
		else $error("ramp goal not zero outside velocity mode");
	slow_time_a: assert property (@(posedge ref_clk) disable iff (rst)
		!stopping && ramp_goal == 16'sh0000 |-> ramp_time == slow_down_time_reg)
		else $error("ramp to zero not using slow-down time");
	up_time_a: assert property (@(posedge ref_clk) disable iff (rst)
		!stopping && ramp_goal != 16'sh0000 &&
		velocity_demand_reg == 16'sh0000 |-> ramp_time == ramp_up_time_reg)
		else $error("start from rest not using ramp-up time");
	demand_rest_a: assert property (@(posedge ref_clk) disable iff (rst)
		velocity_demand_reg == ramp_goal |=> $stable(velocity_demand_reg))
		else $error("demand moved at its goal");
	vcmd_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> velocity_command == $past(velocity_demand_reg))
		else $error("velocity command does not follow demand");
	csp_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		drive.mode == DSV_MODE_CSP |=> status_reg[SW_TARGET] == 1'b0 &&
		status_reg[SW_FOLLOW] == $past(drive.following_error))
		else $error("cyclic position mode bits wrong");
endmodule

// *** rtl/dsv_pkg.sv ***
// Purpose: Shared constants and types for the drive status / velocity block
// Assumes: Object dictionary reached through a simple index-addressed port
// Notes:   Indices are the object numbers, ramp times are in milliseconds
package dsv_pkg;
	// Object indices
	localparam logic [15:0] IDX_STATUS      = 16'h6041;
	localparam logic [15:0] IDX_TARGET_VEL  = 16'h6042;
	localparam logic [15:0] IDX_VEL_DEMAND  = 16'h6043;
	localparam logic [15:0] IDX_VEL_ACTUAL  = 16'h6044;
	localparam logic [15:0] IDX_RAMP_UP     = 16'h604f;
	localparam logic [15:0] IDX_SLOW_DOWN   = 16'h6050;
	localparam logic [15:0] IDX_QUICK_STOP  = 16'h6051;
	// Reset values
	localparam logic [15:0] RST_TARGET_VEL  = 16'h0000;
	localparam logic [31:0] RST_RAMP_UP     = 32'h0000_2710;
	localparam logic [31:0] RST_SLOW_DOWN   = 32'h0000_2710;
	localparam logic [31:0] RST_QUICK_STOP  = 32'h0000_03e8;
	// Quick-stop time limits per time-unit setting
	localparam logic [31:0] QS_MIN_UNIT0    = 32'h0000_000a;
	localparam logic [31:0] QS_MAX_UNIT0    = 32'h0009_27c0;
	localparam logic [31:0] QS_MIN_UNIT1    = 32'h0000_0064;
	localparam logic [31:0] QS_MAX_UNIT1    = 32'h005b_8d80;
	// Status word field positions
	localparam int SW_READY    = 0;
	localparam int SW_ON       = 1;
	localparam int SW_OP_EN    = 2;
	localparam int SW_FAULT    = 3;
	localparam int SW_VOLTAGE  = 4;
	localparam int SW_QSTOP    = 5;
	localparam int SW_DISABLED = 6;
	localparam int SW_WARNING  = 7;
	localparam int SW_REMOTE   = 9;
	localparam int SW_TARGET   = 10;
	localparam int SW_HOMED    = 12;
	localparam int SW_FOLLOW   = 13;
	// Timing: 1 ms tick from a 200 MHz clock
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_TIME_NS  = 1000000;
	localparam int TICK_CYCLES   = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

	// Drive state (one-hot)
	typedef enum logic [7:0] {
		DSV_NOT_READY  = 8'h01,
		DSV_SW_DIS     = 8'h02,
		DSV_READY      = 8'h04,
		DSV_SWITCHED   = 8'h08,
		DSV_OP_EN      = 8'h10,
		DSV_QSTOP      = 8'h20,
		DSV_FAULT_REAC = 8'h40,
		DSV_FAULT      = 8'h80
	} dsv_state_e;

	// Operating modes as coded by the mode selection object
	typedef enum logic [7:0] {
		DSV_MODE_NONE = 8'h00,
		DSV_MODE_PP   = 8'h01,
		DSV_MODE_VL   = 8'h02,
		DSV_MODE_PT   = 8'h04,
		DSV_MODE_HM   = 8'h06,
		DSV_MODE_IP   = 8'h07,
		DSV_MODE_CSP  = 8'h08,
		DSV_MODE_CST  = 8'h0a
	} dsv_mode_e;

	// Drive condition reported by the motor control core
	typedef struct packed {
		dsv_state_e   state;
		dsv_mode_e    mode;
		logic         warning;
		logic         remote;
		logic         target_reached;
		logic         homing_attained;
		logic         homing_error;
		logic         following_error;
		logic         voltage_present;
	} dsv_drive_s;

	// Object access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] index;
		logic [31:0] wdata;
	} dsv_req_s;
endpackage

// *** bench/dsv_master.sv ***
// Purpose: Behavioural fieldbus master that reads and writes drive objects
// Assumes: One-cycle strobes, answer sampled two edges after the request
// Notes:   A released request scrambles index and data so stale values
//          cannot pass for a held request
`timescale 1ns/1ps
module dsv_master (
	// Clock
	input  wire logic          ref_clk,
	// Object access
	output dsv_pkg::dsv_req_s  req
);
	import dsv_pkg::*;

	initial req = '0;

	// Never strobes read and write together
	task automatic access(input logic wr, input logic [15:0] idx,
		input logic [31:0] data);
		@(posedge ref_clk);
		req <= '{wr: wr, rd: !wr, index: idx, wdata: data};
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~data};
		@(posedge ref_clk);
	endtask
endmodule

// *** bench/drive_status_velocity_objects_tb.sv ***
// Purpose: Self-checking bench for the status word and velocity objects
// Assumes: Answers arrive with ack, compared in request order
// Notes:   The millisecond ramp is too slow to run here; demand at rest only
`timescale 1ns/1ps
module drive_status_velocity_objects_tb;
	import dsv_pkg::*;
	typedef struct packed {
		logic        rd;
		logic        err;
		logic [31:0] data;
		logic [31:0] mask;
	} dsv_note_s;
	logic               ref_clk;
	logic               rst;
	logic               unit;
	logic               ack;
	logic               err;
	logic [31:0]        rdata;
	logic signed [15:0] speed;
	logic signed [15:0] vcmd;
	logic [15:0]        sw;
	logic [15:0]        tv;
	logic [31:0]        qs;
	logic [31:0]        rv;
	dsv_req_s           req;
	dsv_drive_s         drive;
	dsv_drive_s         d;
	dsv_note_s          notes[$];
	dsv_note_s          n;
	int                 mismatches;
	int                 comparisons;
	int                 seed;
	dsv_mode_e modes[7] = '{DSV_MODE_PP, DSV_MODE_VL, DSV_MODE_PT,
		DSV_MODE_HM, DSV_MODE_IP, DSV_MODE_CSP, DSV_MODE_CST};
	logic [31:0] qv[8] = '{32'h9, QS_MIN_UNIT0, QS_MAX_UNIT0,
		QS_MAX_UNIT0 + 1, 32'h63, QS_MIN_UNIT1, QS_MAX_UNIT1,
		QS_MAX_UNIT1 + 1};
	logic        qe[8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	dsv_master m (.ref_clk(ref_clk), .req(req));
	dsv_objects DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .ack(ack),
		.err(err), .rdata(rdata), .drive(drive),
		.drive_time_unit_param(unit), .speed_measured(speed),
		.drive_state_word(sw), .velocity_command(vcmd));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [15:0] idx, input logic e,
		input logic [31:0] dat, input logic [31:0] mk);
		notes.push_back('{1'b1, e, dat, mk});
		m.access(1'b0, idx, 32'h0);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] dat,
		input logic e);
		notes.push_back('{1'b0, e, 32'h0, 32'h0});
		m.access(1'b1, idx, dat);
	endtask

	function automatic logic [31:0] sw_exp(input dsv_drive_s x);
		logic [6:0] p;
		logic       b10;
		logic       b12;
		logic       b13;
		case (x.state)
			DSV_SW_DIS:     p = 7'h40;
			DSV_READY:      p = 7'h21;
			DSV_SWITCHED:   p = 7'h23;
			DSV_OP_EN:      p = 7'h27;
			DSV_QSTOP:      p = 7'h07;
			DSV_FAULT_REAC: p = 7'h0f;
			DSV_FAULT:      p = 7'h08;
			default:        p = 7'h00;
		endcase
		b10 = x.target_reached && (x.mode inside {DSV_MODE_PP, DSV_MODE_HM,
			DSV_MODE_IP, DSV_MODE_PT});
		b12 = x.homing_attained && x.mode == DSV_MODE_HM;
		b13 = (x.mode == DSV_MODE_HM) ? x.homing_error : x.following_error
			&& (x.mode inside {DSV_MODE_PP, DSV_MODE_IP, DSV_MODE_CSP});
		return {18'h0, b13, b12, 1'b0, b10, x.remote, 1'b0, x.warning,
			p[6:5], x.voltage_present, p[3:0]};
	endfunction

	// Bit 5 carries no meaning in these states, so it is not compared
	function automatic logic [31:0] sw_mask(input dsv_state_e s);
		if (s inside {DSV_NOT_READY, DSV_SW_DIS, DSV_FAULT_REAC, DSV_FAULT})
			return 32'h0000_ffdf;
		return 32'h0000_ffff;
	endfunction

	always @(posedge ref_clk) begin
		if (ack === 1'b1) begin
			if (notes.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				n = notes.pop_front();
				check({31'h0, err}, {31'h0, n.err});
				if (n.rd && !n.err)
					check(rdata & n.mask, n.data);
			end
		end
	end

	task automatic finish_test();
		if (notes.size() != 0) mismatches++;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// About 300 cycles of traffic; twenty times that means a hang
	initial begin
		#30000;
		mismatches++;
		finish_test();
	end

	initial begin
		seed = 54;
		rst = 1'b1;
		unit = 1'b0;
		speed = 16'sh0;
		drive = '0;
		drive.state = DSV_NOT_READY;
		drive.mode = DSV_MODE_VL;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rd(IDX_TARGET_VEL, 1'b0, 32'h0, '1);
		rd(IDX_RAMP_UP, 1'b0, RST_RAMP_UP, '1);
		rd(IDX_SLOW_DOWN, 1'b0, RST_SLOW_DOWN, '1);
		rd(IDX_QUICK_STOP, 1'b0, RST_QUICK_STOP, '1);
		rd(IDX_VEL_DEMAND, 1'b0, 32'h0, '1);
		rd(16'h6045, 1'b1, 32'h0, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 16; i++) begin
			d = drive;
			d.state = dsv_state_e'(8'h01 << (i % 8));
			d.mode = modes[i % 7];
			{d.warning, d.remote, d.target_reached, d.homing_attained,
				d.homing_error, d.following_error,
				d.voltage_present} = 7'($random(seed));
			drive <= d;
			speed <= 16'($random(seed));
			repeat (2) @(posedge ref_clk);
			check({16'h0, sw} & sw_mask(d.state), sw_exp(d));
			rd(IDX_STATUS, 1'b0, sw_exp(d), sw_mask(d.state));
			rd(IDX_VEL_ACTUAL, 1'b0, 32'(speed), '1);
		end
		$display("test status word done");
		// Velocity mode running, so the ramp goal follows the target
		d.state = DSV_OP_EN;
		d.mode = DSV_MODE_VL;
		drive <= d;
		for (int i = 0; i < 4; i++) begin
			tv = 16'($random(seed));
			rv = $random(seed);
			wr(IDX_TARGET_VEL, {16'h0, tv}, 1'b0);
			rd(IDX_TARGET_VEL, 1'b0, {{16{tv[15]}}, tv}, '1);
			wr(IDX_RAMP_UP, rv, 1'b0);
			rd(IDX_RAMP_UP, 1'b0, rv, '1);
			wr(IDX_SLOW_DOWN, ~rv, 1'b0);
			rd(IDX_SLOW_DOWN, 1'b0, ~rv, '1);
		end
		wr(IDX_STATUS, 32'hffff, 1'b1);
		wr(IDX_VEL_DEMAND, 32'h1, 1'b1);
		wr(IDX_VEL_ACTUAL, 32'h1, 1'b1);
		wr(16'h6045, 32'h1, 1'b1);
		rd(IDX_TARGET_VEL, 1'b0, {{16{tv[15]}}, tv}, '1);
		rd(IDX_VEL_DEMAND, 1'b0, 32'h0, '1);
		check({16'h0, vcmd}, 32'h0);
		$display("test object writes done");
		qs = RST_QUICK_STOP;
		for (int i = 0; i < 8; i++) begin
			unit <= (i >= 4);
			wr(IDX_QUICK_STOP, qv[i], qe[i]);
			if (!qe[i]) qs = qv[i];
			rd(IDX_QUICK_STOP, 1'b0, qs, '1);
		end
		$display("test quick stop range done");
		repeat (2) @(posedge ref_clk);
		finish_test();
	end
endmodule
